// ### rtl/sts_framer_consts.svh
// Purpose: frame geometry, overhead values, timing and register map
// Assumes: octet-rate datapath, one octet per clock
// Notes:   included by the package and every rtl module
`ifndef STS_FRAMER_CONSTS_SVH
`define STS_FRAMER_CONSTS_SVH
`define COL_LAST     15'h437f
`define ROW_LAST     4'h8
`define TOH_COLS     15'h0240
`define TOH_LAST     15'h023f
`define SPE_LAST     15'h413f
`define ENV_LAST     18'h24b3f
`define STUFF_END    15'h003f
`define STUFF_LAST   15'h02ff
`define COL_A2       15'h00c0
`define COL_J0       15'h0180
`define COL_H2       15'h00c0
`define COL_H3       15'h0180
`define COL_K1       15'h00c0
`define COL_K2       15'h0180
`define ROW_FRAME    4'h0
`define ROW_B1       4'h1
`define ROW_COMMIT   4'h2
`define ROW_PTR      4'h3
`define ROW_APS      4'h4
`define ROW_S1       4'h8
`define OCT_A1       8'hf6
`define OCT_A2       8'h28
`define OCT_J0_DEF   8'h02
`define OCT_Z0       8'hcc
`define OCT_H1_CAT   8'h93
`define OCT_H2_CAT   8'hff
`define OCT_K1       8'h01
`define OCT_K2       8'h10
`define OCT_S1       8'h0f
`define NDF_SET      4'h9
`define NDF_NORM     4'h6
`define PTR_DEF      10'h20a
`define PTR_MAX      10'h30e
`define I_BITS       10'h2aa
`define D_BITS       10'h155
`define SCR_SEED     7'h7f
`define MATCH_MIN    4'h8
`define MAJ_MIN      4'h3
`define ADDR_J0_TX   8'h00
`define ADDR_J0_EXP  8'h04
`define ADDR_J0_RX   8'h08
`define ADDR_TX_PTR  8'h0c
`define ADDR_RX_PTR  8'h10
`define ADDR_B1_ERR  8'h14
`define ADDR_EVENTS  8'h18
`endif

// ### rtl/sts_framer_pkg.sv
// Purpose: shared types and helper functions of the framer
// Assumes: constants come from sts_framer_consts.svh
// Notes:   scrambler is x^7+x^6+1, output taken from the x^7 stage
package sts_framer_pkg;
`include "sts_framer_consts.svh"
  typedef logic [7:0]  octet_t;
  typedef logic [3:0]  row_t;
  typedef logic [14:0] col_t;
  typedef logic [17:0] idx_t;
  typedef logic [9:0]  ptr_t;
  typedef enum logic [3:0] {
    JUST_IDLE = 4'b0001,
    JUST_INC  = 4'b0010,
    JUST_DEC  = 4'b0100,
    JUST_NDF  = 4'b1000
  } just_t;

  function automatic logic [3:0] ones10(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction

  // returns {key octet, next state}; msb of the key meets the msb first
  function automatic logic [14:0] scramble(input logic [6:0] seed);
    logic [6:0] s;
    logic [7:0] k;
    s = seed;
    k = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      k[i] = s[6];
      s = {s[5:0], s[6] ^ s[5]};
    end
    return {k, s};
  endfunction

  function automatic idx_t ptrStart(input ptr_t p);
    return idx_t'({p, 7'h0}) + idx_t'({p, 6'h0});
  endfunction

  function automatic ptr_t ptrStep(input ptr_t p, input logic up);
    if (up) return (p == `PTR_MAX) ? 10'h000 : p + 10'h001;
    return (p == 10'h000) ? `PTR_MAX : p - 10'h001;
  endfunction
endpackage

// ### rtl/frame_position.sv
// Purpose: row, column and envelope index of the octet in hand
// Assumes: one step per octet; align marks row 0 column 0
// Notes:   envelope index restarts after the last pointer-action octet
`timescale 1ns/1ps
module frame_position (
  input  logic                 clk,
  input  logic                 reset,
  input  logic                 step,
  input  logic                 align,
  output sts_framer_pkg::row_t row,
  output sts_framer_pkg::col_t col,
  output sts_framer_pkg::idx_t envIdx
);
  import sts_framer_pkg::*;
`include "sts_framer_consts.svh"
  row_t rowR;
  col_t colR;
  idx_t idxR;

  assign row    = align ? `ROW_FRAME : rowR;
  assign col    = align ? 15'h0000 : colR;
  assign envIdx = idxR;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rowR <= `ROW_FRAME;
      colR <= 15'h0000;
    end else if (step) begin
      if (col == `COL_LAST) begin
        colR <= 15'h0000;
        rowR <= (row == `ROW_LAST) ? `ROW_FRAME : row + 4'h1;
      end else begin
        colR <= col + 15'h0001;
        rowR <= row;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) idxR <= 18'h00000;
    else if (step && row == `ROW_PTR && col == `TOH_LAST) idxR <= 18'h00000;
    else if (step && col >= `TOH_COLS) idxR <= (idxR == `ENV_LAST) ? 18'h00000 : idxR + 18'h00001;
  end
endmodule

// ### rtl/pointer_interpreter.sv
// Purpose: receive payload pointer interpretation
// Assumes: ptrWord holds first H1 (high) and first H2 (low) octets
// Notes:   decision pulses one clock after wordValid
`timescale 1ns/1ps
module pointer_interpreter (
  input  logic                 clk,
  input  logic                 reset,
  input  logic                 wordValid,
  input  logic [15:0]          ptrWord,
  output sts_framer_pkg::ptr_t offset,
  output logic                 incEv,
  output logic                 decEv,
  output logic                 ndfEv
);
  import sts_framer_pkg::*;
`include "sts_framer_consts.svh"
  ptr_t       rxPtr;
  logic [3:0] normHits;
  logic [3:0] setHits;
  logic [3:0] incHits;
  logic [3:0] decHits;
  logic [3:0] iInv;
  logic [3:0] dInv;
  logic       isNdf;
  logic       isNorm;
  logic       inc8;
  logic       dec8;
  logic       doInc;
  logic       doDec;

  assign rxPtr    = ptrWord[9:0];
  assign normHits = ones10({6'h00, ~(ptrWord[15:12] ^ `NDF_NORM)});
  assign setHits  = ones10({6'h00, ~(ptrWord[15:12] ^ `NDF_SET)});
  assign isNorm   = normHits >= `MAJ_MIN;
  assign isNdf    = setHits >= `MAJ_MIN && rxPtr <= `PTR_MAX;
  assign incHits  = ones10(~(rxPtr ^ offset ^ `I_BITS));
  assign decHits  = ones10(~(rxPtr ^ offset ^ `D_BITS));
  assign iInv     = ones10((rxPtr ^ offset) & `I_BITS);
  assign dInv     = ones10((rxPtr ^ offset) & `D_BITS);
  assign inc8     = incHits >= `MATCH_MIN;
  assign dec8     = decHits >= `MATCH_MIN;
  // majority fallback only when neither 8-of-10 match holds; both inverted means no action
  assign doInc = isNorm && (inc8 || (!dec8 && iInv >= `MAJ_MIN && dInv < `MAJ_MIN));
  assign doDec = isNorm && (dec8 || (!inc8 && dInv >= `MAJ_MIN && iInv < `MAJ_MIN));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      offset <= `PTR_DEF;
      incEv  <= 1'b0;
      decEv  <= 1'b0;
      ndfEv  <= 1'b0;
    end else begin
      incEv <= wordValid && !isNdf && doInc;
      decEv <= wordValid && !isNdf && doDec;
      ndfEv <= wordValid && isNdf;
      if (wordValid) begin
        if (isNdf) offset <= rxPtr;
        else if (doInc) offset <= ptrStep(offset, 1'b1);
        else if (doDec) offset <= ptrStep(offset, 1'b0);
      end
    end
  end
endmodule

// ### rtl/sts192c_transport_overhead_framer.sv
// Purpose: STS-192c frame builder and payload extractor with APB registers
// Assumes: receive octets arrive already frame-aligned, one per valid
// Notes:   path overhead column is sent as zero; B1 is checked on receive
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sts192c_transport_overhead_framer (
  input  logic                   clk,
  input  logic                   reset,
  input  logic                   psel,
  input  logic                   penable,
  input  logic                   pwrite,
  input  logic [7:0]             paddr,
  input  logic [31:0]            pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  sts_framer_pkg::octet_t txOctet,
  output logic                   txAccept,
  input  logic                   justificationRequest,
  input  logic                   justificationPositive,
  output logic [15:0]            txWord,
  output logic                   txWordValid,
  input  sts_framer_pkg::octet_t rxOctet,
  input  logic                   rxOctetValid,
  input  logic                   rxFrameStart,
  input  logic                   rxInSync,
  output sts_framer_pkg::octet_t rxPayload,
  output logic                   rxPayloadValid
);
  import sts_framer_pkg::*;
`include "sts_framer_consts.svh"

  row_t        tRow;
  col_t        tCol;
  idx_t        tIdx;
  col_t        tSpe;
  col_t        tCurSpe;
  ptr_t        tPtr;
  ptr_t        tPtrNew;
  ptr_t        tPtrOut;
  logic [3:0]  tNdf;
  just_t       tJust;
  logic        pendInc;
  logic        pendDec;
  logic        pendNdf;
  logic        commit;
  logic        txOh;
  logic        txStuff;
  logic        txNeg;
  logic        txSlot;
  logic        txScrOn;
  logic [6:0]  tScr;
  logic [14:0] tKey;
  octet_t      tPre;
  octet_t      tOut;
  octet_t      tAcc;
  octet_t      tBip;
  octet_t      tHi;
  logic        tHalf;
  octet_t      j0Tx;
  octet_t      j0Exp;

  row_t        rRow;
  col_t        rCol;
  idx_t        rIdx;
  col_t        rSpe;
  col_t        rCurSpe;
  ptr_t        rOffset;
  just_t       rJust;
  logic        rxStep;
  logic        rxOh;
  logic        rxStuff;
  logic        rxNeg;
  logic        rxSlot;
  logic        rxScrOn;
  logic        rxLocked;
  logic [6:0]  rScr;
  logic [14:0] rKey;
  octet_t      rDesc;
  octet_t      rAcc;
  octet_t      rBip;
  octet_t      rH1;
  octet_t      j0Rx;
  logic        j0Mis;
  logic        j0MisEv;
  logic        incEv;
  logic        decEv;
  logic        ndfEv;
  logic [15:0] b1Err;
  logic [3:0]  b1Bits;
  logic [3:0]  events;
  logic        apbWr;
  logic        hit;
  logic [31:0] rdMux;

  // transmit side

  frame_position txPos (
    .clk    (clk),
    .reset  (reset),
    .step   (1'b1),
    .align  (1'b0),
    .row    (tRow),
    .col    (tCol),
    .envIdx (tIdx)
  );

  assign txOh    = tCol < `TOH_COLS;
  assign commit  = tRow == `ROW_COMMIT && tCol == `COL_LAST;
  assign txStuff = tJust == JUST_INC && tRow == `ROW_PTR && !txOh && tCol <= `STUFF_LAST;
  assign txNeg   = tJust == JUST_DEC && tRow == `ROW_PTR && txOh && tCol >= `COL_H3;
  assign txSlot  = (!txOh && !txStuff) || txNeg;
  assign tCurSpe = (!txOh && tIdx == ptrStart(tPtr)) ? 15'h0000 : tSpe;
  assign txAccept = txSlot && tCurSpe > `STUFF_END;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) tSpe <= 15'h0000;
    else if (txSlot) tSpe <= (tCurSpe == `SPE_LAST) ? 15'h0000 : tCurSpe + 15'h0001;
  end

  // a pending action is chosen just before the pointer row and held through it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) tJust <= JUST_IDLE;
    else if (commit) begin
      if (pendNdf) tJust <= JUST_NDF;
      else if (pendInc) tJust <= JUST_INC;
      else if (pendDec) tJust <= JUST_DEC;
      else tJust <= JUST_IDLE;
    end else if (tRow == `ROW_APS && tCol == 15'h0000) tJust <= JUST_IDLE;
  end

  // new requests in the commit cycle stay pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pendInc <= 1'b0;
      pendDec <= 1'b0;
      pendNdf <= 1'b0;
      tPtrNew <= `PTR_DEF;
    end else begin
      if (commit) begin
        pendNdf <= 1'b0;
        if (!pendNdf && pendInc) pendInc <= 1'b0;
        if (!pendNdf && !pendInc) pendDec <= 1'b0;
      end
      if (justificationRequest && justificationPositive) pendInc <= 1'b1;
      if (justificationRequest && !justificationPositive) pendDec <= 1'b1;
      if (apbWr && paddr == `ADDR_TX_PTR && pwdata[9:0] <= `PTR_MAX) begin
        pendNdf <= 1'b1;
        tPtrNew <= pwdata[9:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) tPtr <= `PTR_DEF;
    else if (commit && pendNdf) tPtr <= tPtrNew;
    else if (tRow == `ROW_PTR && tCol == `TOH_LAST && tJust == JUST_INC) tPtr <= ptrStep(tPtr, 1'b1);
    else if (tRow == `ROW_PTR && tCol == `TOH_LAST && tJust == JUST_DEC) tPtr <= ptrStep(tPtr, 1'b0);
  end

  always_comb begin
    tPtrOut = tPtr;
    tNdf = `NDF_NORM;
    case (tJust)
      JUST_INC: tPtrOut = tPtr ^ `I_BITS;
      JUST_DEC: tPtrOut = tPtr ^ `D_BITS;
      JUST_NDF: tNdf = `NDF_SET;
      default: tPtrOut = tPtr;
    endcase
  end

  always_comb begin
    tPre = 8'h00;
    if (!txOh) begin
      if (!txStuff && tCurSpe > `STUFF_END) tPre = txOctet;
    end else begin
      case (tRow)
        `ROW_FRAME: begin
          if (tCol < `COL_A2) tPre = `OCT_A1;
          else if (tCol < `COL_J0) tPre = `OCT_A2;
          else if (tCol == `COL_J0) tPre = j0Tx;
          else tPre = `OCT_Z0;
        end
        `ROW_B1: if (tCol == 15'h0000) tPre = tBip;
        `ROW_PTR: begin
          if (tCol == 15'h0000) tPre = {tNdf, 2'h0, tPtrOut[9:8]};
          else if (tCol < `COL_H2) tPre = `OCT_H1_CAT;
          else if (tCol == `COL_H2) tPre = tPtrOut[7:0];
          else if (tCol < `COL_H3) tPre = `OCT_H2_CAT;
          else if (txNeg && tCurSpe > `STUFF_END) tPre = txOctet;
        end
        `ROW_APS: begin
          if (tCol == `COL_K1) tPre = `OCT_K1;
          else if (tCol == `COL_K2) tPre = `OCT_K2;
        end
        `ROW_S1: if (tCol == 15'h0000) tPre = `OCT_S1;
        default: tPre = 8'h00;
      endcase
    end
  end

  // framing, trace and growth octets bypass the scrambler
  assign txScrOn = !(tRow == `ROW_FRAME && txOh);
  assign tKey    = scramble(tScr);
  assign tOut    = txScrOn ? tPre ^ tKey[14:7] : tPre;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) tScr <= `SCR_SEED;
    else if (tRow == `ROW_FRAME && tCol == `TOH_LAST) tScr <= `SCR_SEED;
    else if (txScrOn) tScr <= tKey[6:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tAcc <= 8'h00;
      tBip <= 8'h00;
    end else if (tRow == `ROW_FRAME && tCol == 15'h0000) begin
      tBip <= tAcc;
      tAcc <= tOut;
    end else tAcc <= tAcc ^ tOut;
  end

  // frame length is even, so the high byte always holds an even column
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tHalf       <= 1'b0;
      tHi         <= 8'h00;
      txWord      <= 16'h0000;
      txWordValid <= 1'b0;
    end else begin
      tHalf <= ~tHalf;
      txWordValid <= tHalf;
      if (!tHalf) tHi <= tOut;
      else txWord <= {tHi, tOut};
    end
  end

  // receive side

  assign rxStep = rxOctetValid && rxInSync;

  frame_position rxPos (
    .clk    (clk),
    .reset  (reset),
    .step   (rxStep),
    .align  (rxFrameStart && rxStep),
    .row    (rRow),
    .col    (rCol),
    .envIdx (rIdx)
  );

  assign rxScrOn = !(rRow == `ROW_FRAME && rCol < `TOH_COLS);
  assign rKey    = scramble(rScr);
  assign rDesc   = rxScrOn ? rxOctet ^ rKey[14:7] : rxOctet;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rScr <= `SCR_SEED;
    else if (rxStep && rRow == `ROW_FRAME && rCol == `TOH_LAST) rScr <= `SCR_SEED;
    else if (rxStep && rxScrOn) rScr <= rKey[6:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rAcc <= 8'h00;
      rBip <= 8'h00;
    end else if (rxStep && rRow == `ROW_FRAME && rCol == 15'h0000) begin
      rBip <= rAcc;
      rAcc <= rxOctet;
    end else if (rxStep) rAcc <= rAcc ^ rxOctet;
  end

  assign b1Bits = ones10({2'h0, rDesc ^ rBip});

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rH1     <= 8'h00;
      j0Rx    <= 8'h00;
      j0Mis   <= 1'b0;
      j0MisEv <= 1'b0;
    end else begin
      j0MisEv <= 1'b0;
      if (rxStep && rRow == `ROW_PTR && rCol == 15'h0000) rH1 <= rDesc;
      if (rxStep && rRow == `ROW_FRAME && rCol == `COL_J0) begin
        j0Rx    <= rxOctet;
        j0Mis   <= rxOctet != j0Exp;
        j0MisEv <= rxOctet != j0Exp;
      end
    end
  end

  pointer_interpreter ptrRx (
    .clk       (clk),
    .reset     (reset),
    .wordValid (rxStep && rRow == `ROW_PTR && rCol == `COL_H2),
    .ptrWord   ({rH1, rDesc}),
    .offset    (rOffset),
    .incEv     (incEv),
    .decEv     (decEv),
    .ndfEv     (ndfEv)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rJust <= JUST_IDLE;
    else if (incEv) rJust <= JUST_INC;
    else if (decEv) rJust <= JUST_DEC;
    else if (rxStep && rRow == `ROW_APS && rCol == 15'h0000) rJust <= JUST_IDLE;
  end

  assign rxOh    = rCol < `TOH_COLS;
  assign rxStuff = rJust == JUST_INC && rRow == `ROW_PTR && !rxOh && rCol <= `STUFF_LAST;
  assign rxNeg   = rJust == JUST_DEC && rRow == `ROW_PTR && rxOh && rCol >= `COL_H3;
  assign rxSlot  = (!rxOh && !rxStuff) || rxNeg;
  assign rCurSpe = (!rxOh && rIdx == ptrStart(rOffset)) ? 15'h0000 : rSpe;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rSpe <= 15'h0000;
    else if (rxStep && rxSlot) rSpe <= (rCurSpe == `SPE_LAST) ? 15'h0000 : rCurSpe + 15'h0001;
  end

  // nothing is delivered until the envelope start has been seen once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rxLocked <= 1'b0;
    else if (!rxInSync) rxLocked <= 1'b0;
    else if (rxStep && !rxOh && rIdx == ptrStart(rOffset)) rxLocked <= 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxPayload      <= 8'h00;
      rxPayloadValid <= 1'b0;
    end else begin
      rxPayloadValid <= rxStep && rxSlot && rxLocked && rCurSpe > `STUFF_END;
      if (rxStep && rxSlot && rCurSpe > `STUFF_END) rxPayload <= rDesc;
    end
  end

  // register bus

  assign apbWr   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    hit = 1'b1;
    rdMux = 32'h00000000;
    case (paddr)
      `ADDR_J0_TX:  rdMux = {24'h000000, j0Tx};
      `ADDR_J0_EXP: rdMux = {24'h000000, j0Exp};
      `ADDR_J0_RX:  rdMux = {23'h000000, j0Mis, j0Rx};
      `ADDR_TX_PTR: rdMux = {22'h000000, tPtr};
      `ADDR_RX_PTR: rdMux = {15'h0000, rxLocked, 6'h00, rOffset};
      `ADDR_B1_ERR: rdMux = {16'h0000, b1Err};
      `ADDR_EVENTS: rdMux = {28'h0000000, events};
      default:      hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) prdata <= 32'h00000000;
    else if (psel && !penable) prdata <= pwrite ? 32'h00000000 : rdMux;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      j0Tx  <= `OCT_J0_DEF;
      j0Exp <= `OCT_J0_DEF;
    end else begin
      if (apbWr && paddr == `ADDR_J0_TX) j0Tx <= pwdata[7:0];
      if (apbWr && paddr == `ADDR_J0_EXP) j0Exp <= pwdata[7:0];
    end
  end

  // a write clears the count but errors seen in the same cycle are kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) b1Err <= 16'h0000;
    else if (rxStep && rRow == `ROW_B1 && rCol == 15'h0000) begin
      if (apbWr && paddr == `ADDR_B1_ERR) b1Err <= {12'h000, b1Bits};
      else if (b1Err > 16'hfff7) b1Err <= 16'hffff;
      else b1Err <= b1Err + {12'h000, b1Bits};
    end else if (apbWr && paddr == `ADDR_B1_ERR) b1Err <= 16'h0000;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) events <= 4'h0;
    else events <= (events & ~((apbWr && paddr == `ADDR_EVENTS) ? pwdata[3:0] : 4'h0))
                   | {j0MisEv, ndfEv, decEv, incEv};
  end
endmodule

// ### verif/framer_asserts.sv
// Purpose: port checks of the framer
// Assumes: default pointer holds through the row 3 overhead of frame 0
// Notes:   counters saturate, so the counted checks stop in row 3 of the first frame
`timescale 1ns/1ps
module framer_asserts (
  input logic        clk,
  input logic        reset,
  input logic        txAccept,
  input logic [15:0] txWord,
  input logic        txWordValid
);
  logic [15:0] cyc;
  logic [15:0] wc;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cyc <= 16'h0000;
      wc  <= 16'h0000;
    end else begin
      cyc <= cyc + {15'h0000, cyc != 16'hffff};
      wc  <= wc + {15'h0000, txWordValid && wc != 16'hffff};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // row 3 from column 576 on may be a stuff window, so stop before it
  word_alt_a: assert property (txWordValid |=> !txWordValid) else $error("word cadence");
  oh_gap_a: assert property (cyc < 16'hccc0 && cyc % 16'h4380 < 16'h0280 |-> !txAccept) else $error("accept");
  pay_open_a: assert property (cyc < 16'hccc0 && cyc % 16'h4380 >= 16'h0280 |-> txAccept) else $error("gap");
  a1_word_a: assert property (txWordValid && wc < 16'h0060 |-> txWord == 16'hf6f6) else $error("A1 word");
  a2_word_a: assert property (txWordValid && wc >= 16'h0060 && wc < 16'h00c0 |-> txWord == 16'h2828) else $error("A2");
  trace_word_a: assert property (txWordValid && wc == 16'h00c0 |-> txWord == 16'h02cc) else $error("trace");
  growth_word_a: assert property (txWordValid && wc > 16'h00c0 && wc < 16'h0120 |-> txWord == 16'hcccc) else $error("Z0");
  scr_seed_a: assert property (txWordValid && wc == 16'h0120 |-> txWord == 16'hfe04) else $error("seed");
endmodule

bind sts192c_transport_overhead_framer framer_asserts chk (.clk, .reset, .txAccept, .txWord, .txWordValid);

// ### verif/media_loop.sv
// Purpose: line loopback in place of the media attachment
// Assumes: one tx word every second clock
// Notes:   octets before the first word are noise, never stale
`timescale 1ns/1ps
module media_loop (
  input  logic        clk,
  input  logic        reset,
  input  logic [15:0] txWord,
  input  logic        txWordValid,
  output logic [7:0]  rxOctet,
  output logic        rxOctetValid,
  output logic        rxFrameStart,
  output logic        rxInSync
);
  logic [7:0]  low;
  logic [16:0] wn;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxOctet      <= 8'h00;
      rxOctetValid <= 1'b0;
      rxFrameStart <= 1'b0;
      low          <= 8'h00;
      wn           <= 17'h00000;
    end else if (txWordValid) begin
      rxOctet      <= txWord[15:8];
      low          <= txWord[7:0];
      rxOctetValid <= 1'b1;
      rxFrameStart <= wn == 17'h00000;
      wn           <= (wn == 17'h12fbf) ? 17'h00000 : wn + 17'h00001;
    end else begin
      rxOctet      <= rxOctetValid ? low : ~rxOctet;
      rxFrameStart <= 1'b0;
    end
  end
  assign rxInSync = rxOctetValid;
endmodule

// ### verif/tb.sv
// Purpose: self-checking bench of the framer
// Assumes: line side looped back by media_loop
// Notes:   a full frame is too long, so each run stops in row 3
`timescale 1ns/1ps
module tb;
  import sts_framer_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        pready, pslverr, txAccept, txWordValid, rxOctetValid, rxFrameStart, rxInSync, rxPayloadValid;
  logic        justificationRequest = 1'b0, justificationPositive = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] txWord;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  octet_t      txOctet = 8'h00, rxOctet, rxPayload;
  octet_t      q[$];
  int          error_cnt = 0, compares = 0, pays = 0;
  always #5 clk = ~clk;
  sts192c_transport_overhead_framer dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .txOctet, .txAccept, .justificationRequest, .justificationPositive, .txWord,
    .txWordValid, .rxOctet, .rxOctetValid, .rxFrameStart, .rxInSync, .rxPayload, .rxPayloadValid);
  media_loop far (.clk, .reset, .txWord, .txWordValid, .rxOctet, .rxOctetValid, .rxFrameStart, .rxInSync);
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  always @(posedge clk) begin
    if (txAccept === 1'b1) begin
      q.push_back(txOctet);
      txOctet <= txOctet + 8'h01;
    end
    if (rxPayloadValid === 1'b1) begin
      pays++;
      // a delivery with nothing sent is a mismatch, never skipped
      if (q.size() > 0) cmp("rxPayload", {24'h0, q.pop_front()}, {24'h0, rxPayload});
      else cmp("rxPayload queue", 32'h00000001, 32'h00000000);
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    justificationRequest <= 1'b1;
    @(posedge clk);
    justificationRequest <= 1'b0;
    repeat (700) @(posedge clk);
    apb(1'b1, 8'h00, 32'h000000a5);
    apb(1'b0, 8'h00, 32'h0);
    cmp("J0_TX", 32'h000000a5, rd);
    apb(1'b0, 8'h04, 32'h0);
    cmp("J0_EXP", 32'h00000002, rd);
    apb(1'b1, 8'h0c, 32'h000003ff);
    apb(1'b0, 8'h0c, 32'h0);
    cmp("TX_PTR", 32'h0000020a, rd);
    apb(1'b0, 8'h1c, 32'h0);
    cmp("pslverr", 32'h00000001, {31'h0, err});
    repeat (51760) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    cmp("TX_PTR", 32'h0000020b, rd);
    apb(1'b0, 8'h10, 32'h0);
    cmp("RX_PTR", 32'h0000020b, rd & 32'h000003ff);
    apb(1'b0, 8'h18, 32'h0);
    cmp("EVENTS", 32'h00000001, rd);
    apb(1'b1, 8'h18, 32'h00000001);
    apb(1'b0, 8'h18, 32'h0);
    cmp("EVENTS", 32'h0, rd);
    // second run from reset: a new-data pointer of 0 puts the envelope start in row 3
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b1, 8'h0c, 32'h00000000);
    repeat (51997) @(posedge clk);
    // octets of rows 0..2 lie before the envelope start and are never delivered
    q.delete();
    repeat (600) @(posedge clk);
    cmp("rxPayload seen", 32'h00000001, {31'h0, pays > 0});
    apb(1'b0, 8'h0c, 32'h0);
    cmp("TX_PTR", 32'h00000000, rd);
    apb(1'b0, 8'h10, 32'h0);
    cmp("RX_PTR", 32'h00010000, rd);
    apb(1'b0, 8'h18, 32'h0);
    cmp("EVENTS", 32'h00000004, rd);
    apb(1'b0, 8'h08, 32'h0);
    cmp("J0_RX", 32'h00000002, rd);
    apb(1'b0, 8'h14, 32'h0);
    cmp("B1_ERR", 32'h00000000, rd);
    tally_and_finish();
  end
endmodule
